//--- rtl/scg_consts.svh
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SCG_CFG_OFFSET      8'h2c
`define SCG_EN_OFFSET       8'h30
`define SCG_ADDR_W          8

// ****************************************************************
// Field positions
// ****************************************************************
`define SCG_BAUD_SEL_BIT    16
`define SCG_LOW_MSB         10
`define SCG_LOW_LSB         8
`define SCG_HIGH_MSB        2
`define SCG_HIGH_LSB        0
`define SCG_DSLP_BIT        16
`define SCG_SLP_BIT         8
`define SCG_RUN_BIT         0

// ****************************************************************
// Byte lanes holding the writable fields
// ****************************************************************
`define SCG_LANE_B0         0
`define SCG_LANE_B1         1
`define SCG_LANE_B2         2

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define SCG_TIME_RST        3'h0
`define SCG_BIT_RST         1'h0
`define SCG_DSLP_VALUE      1'h0
`define SCG_CNT_ONE         3'h1
`define SCG_ZERO_WORD       32'h0000_0000

`endif

//--- rtl/scg_pkg.sv
`default_nettype none

package scg_pkg;

  // ****************************************************************
  // Bus handshake states
  // ****************************************************************
  typedef enum logic [0:0] {
    SCG_IDLE,
    SCG_ACK
  } scg_bus_e;

  // Power mode of the surrounding system
  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_SLEEP,
    SCG_DEEP_SLEEP,
    SCG_MODE_OFF
  } scg_mode_e;

  typedef logic [2:0] scg_time_t;

  // Avalon-MM slave request as seen by the block
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } scg_avm_req_s;

  // Whole state of the block
  typedef struct packed {
    scg_bus_e    bus;
    logic        waitreq;
    logic [31:0] rdata;
    logic        baud_sel;
    scg_time_t   low_time;
    scg_time_t   high_time;
    logic        slp_gate;
    logic        run_gate;
    scg_time_t   cur_low;
    scg_time_t   cur_high;
    logic        cur_sel;
    logic        gate_on;
    scg_time_t   cnt;
    logic        div_clk;
    logic        func_clk;
    logic        baud_clk;
  } scg_state_s;

endpackage : scg_pkg

`default_nettype wire

//--- rtl/scg_top.sv
// Behaviour
// - Bit 16 of the config register picks crystal (0) or divided PLL (1) as baud clock.
// - Bits 10-8 give the low time of the divided clock, code n means n+1 PLL periods.
// - Bits 2-0 give the high time of the divided clock, code n means n+1 PLL periods.
// - The config register lives at 2Ch and resets to zero.
// - The deep-sleep enable at bit 16 of the enable register is read-only zero.
// - Bit 8 of the enable register lets the clock run in sleep mode when set.
// - Bit 0 of the enable register lets the clock run in run mode when set.
// - The enable register lives at 30h and resets to zero, clock off everywhere.

`timescale 1ns/10ps
`default_nettype none

`include "scg_consts.svh"

module scg_top
  import scg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Clock sources and power mode
  input  wire logic        xtal_clk_i,
  input  wire scg_mode_e   power_mode_i,
  // Clocks to the serial controller
  output logic             func_clk_o,
  output logic             baud_clk_o,
  output logic             func_clk_active_o
);

  // ****************************************************************
  // Register selection
  // ****************************************************************

  // Shared by the read path and the write path
  function automatic logic [1:0] reg_hit(input logic [7:0] addr);
    logic [1:0] hit;
    hit = 2'b00;
    if (addr == `SCG_CFG_OFFSET)
    begin
      hit = 2'b01;
    end
    else if (addr == `SCG_EN_OFFSET)
    begin
      hit = 2'b10;
    end
    return hit;
  endfunction : reg_hit

  scg_avm_req_s req;
  scg_state_s   st_reg;
  scg_state_s   st_next;
  logic [1:0]   hit;
  logic [31:0]  cfg_word;
  logic [31:0]  en_word;
  logic         want_gate;
  logic         period_end;

  // Bundle the bus inputs
  assign req = '{address:    avs_address_i,
                 read:       avs_read_i,
                 write:      avs_write_i,
                 writedata:  avs_writedata_i,
                 byteenable: avs_byteenable_i};

  // ****************************************************************
  // Read images of the two registers
  // ****************************************************************

  // Unused positions stay zero by construction
  always_comb
  begin
    cfg_word = `SCG_ZERO_WORD;
    cfg_word[`SCG_BAUD_SEL_BIT] = st_reg.baud_sel;
    cfg_word[`SCG_LOW_MSB:`SCG_LOW_LSB] = st_reg.low_time;
    cfg_word[`SCG_HIGH_MSB:`SCG_HIGH_LSB] = st_reg.high_time;
    en_word = `SCG_ZERO_WORD;
    en_word[`SCG_DSLP_BIT] = `SCG_DSLP_VALUE;
    en_word[`SCG_SLP_BIT] = st_reg.slp_gate;
    en_word[`SCG_RUN_BIT] = st_reg.run_gate;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Deep sleep never has a gate bit, so it always stops the clock
  always_comb
  begin
    case (power_mode_i)
      SCG_RUN:   want_gate = st_reg.run_gate;
      SCG_SLEEP: want_gate = st_reg.slp_gate;
      default:   want_gate = 1'b0;
    endcase
  end

  // Last low cycle of the divider: the only point where settings move
  assign period_end = !st_reg.div_clk && (st_reg.cnt == st_reg.cur_low);

  always_comb
  begin
    st_next = st_reg;
    hit = reg_hit(req.address);

    // Bus handshake: one wait cycle, then waitrequest low for one edge
    case (st_reg.bus)
      SCG_IDLE:
      begin
        st_next.waitreq = 1'b1;
        if (req.read || req.write)
        begin
          st_next.bus = SCG_ACK;
          st_next.waitreq = 1'b0;
          if (hit == 2'b01)
          begin
            st_next.rdata = cfg_word;
          end
          else if (hit == 2'b10)
          begin
            st_next.rdata = en_word;
          end
          else
          begin
            st_next.rdata = `SCG_ZERO_WORD;                      // Unmapped
          end
        end
      end
      SCG_ACK:
      begin
        st_next.bus = SCG_IDLE;
        st_next.waitreq = 1'b1;
        // Write lands at the edge the master sees waitrequest low
        if (req.write && hit == 2'b01)
        begin
          if (req.byteenable[`SCG_LANE_B2])
          begin
            st_next.baud_sel =
              req.writedata[`SCG_BAUD_SEL_BIT];
          end
          if (req.byteenable[`SCG_LANE_B1])
          begin
            st_next.low_time =
              req.writedata[`SCG_LOW_MSB:`SCG_LOW_LSB];
          end
          if (req.byteenable[`SCG_LANE_B0])
          begin
            st_next.high_time =
              req.writedata[`SCG_HIGH_MSB:`SCG_HIGH_LSB];
          end
        end
        else if (req.write && hit == 2'b10)
        begin
          if (req.byteenable[`SCG_LANE_B1])
          begin
            st_next.slp_gate = req.writedata[`SCG_SLP_BIT];
          end
          if (req.byteenable[`SCG_LANE_B0])
          begin
            st_next.run_gate = req.writedata[`SCG_RUN_BIT];
          end
        end
      end
      default:
      begin
        st_next.bus = SCG_IDLE;
        st_next.waitreq = 1'b1;
      end
    endcase

    // Divider: counts block clock cycles as PLL periods
    if (st_reg.div_clk)
    begin
      if (st_reg.cnt == st_reg.cur_high)
      begin
        st_next.div_clk = 1'b0;
        st_next.cnt = `SCG_TIME_RST;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + `SCG_CNT_ONE;
      end
    end
    else
    begin
      if (period_end)
      begin
        st_next.div_clk = 1'b1;
        st_next.cnt = `SCG_TIME_RST;
        // New times, source and gate opening only at a period boundary,
        // so no runt pulse reaches the controller from the divided clock
        st_next.cur_high = st_reg.high_time;
        st_next.cur_low = st_reg.low_time;
        st_next.cur_sel = st_reg.baud_sel;
        st_next.gate_on = want_gate;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + `SCG_CNT_ONE;
      end
    end

    // Gating drops only while low, so high pulses are never cut
    if (!st_reg.div_clk && !want_gate)
    begin
      st_next.gate_on = 1'b0;
    end

    // Registered clock outputs
    st_next.func_clk = st_next.div_clk && st_next.gate_on;
    // Crystal path passes straight through; its own switch point
    // is not aligned to the crystal edges
    st_next.baud_clk = st_next.cur_sel ?
                       (st_next.div_clk && st_next.gate_on) :
                       (xtal_clk_i && st_next.gate_on);
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_reg <= '{bus:       SCG_IDLE,
                  waitreq:   1'b1,
                  rdata:     `SCG_ZERO_WORD,
                  baud_sel:  `SCG_BIT_RST,
                  low_time:  `SCG_TIME_RST,
                  high_time: `SCG_TIME_RST,
                  slp_gate:  `SCG_BIT_RST,
                  run_gate:  `SCG_BIT_RST,
                  cur_low:   `SCG_TIME_RST,
                  cur_high:  `SCG_TIME_RST,
                  cur_sel:   `SCG_BIT_RST,
                  gate_on:   1'b0,
                  cnt:       `SCG_TIME_RST,
                  div_clk:   1'b0,
                  func_clk:  1'b0,
                  baud_clk:  1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************

  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.waitreq;
  assign func_clk_o        = st_reg.func_clk;
  assign baud_clk_o        = st_reg.baud_clk;
  assign func_clk_active_o = st_reg.gate_on;

endmodule : scg_top

`default_nettype wire

//--- verif/scg_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Serial core clock receiver: counts edges and level run lengths
// ****************************************************************
module scg_core_model (
  // Clocks in
  input  wire logic       clk_i,
  input  wire logic       func_clk_i,
  input  wire logic       baud_clk_i,
  input  wire logic       clr_i,
  // Measurements
  output logic      [7:0] f_rises_o,
  output logic      [7:0] b_rises_o,
  output logic      [4:0] hi_len_o,
  output logic      [4:0] lo_len_o
);
  logic [4:0] run = 5'h00;
  logic       f_q = 1'b0;
  logic       b_q = 1'b0;
  logic       chg;
  // The core only sees edges, so levels are timed between changes
  assign chg = func_clk_i != f_q;
  // Run lengths and edge counts, cleared for each window
  always_ff @(posedge clk_i)
  begin
    f_q <= func_clk_i;
    b_q <= baud_clk_i;
    run <= chg ? 5'h01 : run + 5'h01;
    f_rises_o <= clr_i ? 8'h00 : f_rises_o + 8'(func_clk_i && !f_q);
    b_rises_o <= clr_i ? 8'h00 : b_rises_o + 8'(baud_clk_i && !b_q);
    hi_len_o <= clr_i ? 5'h00 : (chg && f_q) ? run : hi_len_o;
    lo_len_o <= clr_i ? 5'h00 : (chg && !f_q) ? run : lo_len_o;
  end
endmodule : scg_core_model
`default_nettype wire

//--- verif/scg_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module scg_top_properties
  import scg_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // Bus
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Clocks
  input wire logic        xtal_clk_i,
  input wire scg_mode_e   power_mode_i,
  input wire logic        func_clk_o,
  input wire logic        baud_clk_o,
  input wire logic        func_clk_active_o
);
  logic [4:0] off_cnt;
  logic       rgo;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  assign rgo = avs_read_i && avs_waitrequest_o;
  // Cycles in a mode whose clock is fixed off; gate shuts within 20
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || power_mode_i < SCG_DEEP_SLEEP)
      off_cnt <= 5'h00;
    else if (off_cnt != 5'h1f)
      off_cnt <= off_cnt + 5'h01;
  end
  chk_bus_answer:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bad answer");
  chk_reset_idle:
    assert property ($fell(rst_i) |-> avs_waitrequest_o && !func_clk_o &&
      avs_readdata_o == 32'h0) else $error("outputs busy after reset");
  chk_deep_off:
    assert property (off_cnt > 5'h13 |-> !func_clk_o && !baud_clk_o)
      else $error("clock runs in deep sleep");
  chk_high_max:
    assert property ($rose(func_clk_o) |-> ##[1:8] !func_clk_o)
      else $error("high phase too long");
  chk_low_max:
    assert property ($fell(func_clk_o) && func_clk_active_o |->
      ##[1:8] (func_clk_o || !func_clk_active_o)) else $error("low too long");
  chk_gate_shut:
    assert property (!func_clk_active_o |-> !func_clk_o)
      else $error("clock runs with gate shut");
  chk_unmapped_zero:
    assert property (rgo && avs_address_i != 8'h2c && avs_address_i != 8'h30
      |=> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_enable_mask:
    assert property (rgo && avs_address_i == 8'h30 |=>
      (avs_readdata_o & 32'hfffffefe) == 32'h0) else $error("enable bits");
  chk_config_mask:
    assert property (rgo && avs_address_i == 8'h2c |=>
      (avs_readdata_o & 32'hfffef8f8) == 32'h0) else $error("config bits");
endmodule : scg_top_properties
`default_nettype wire

//--- verif/spi_clock_config_gate_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Register and clock tests
// ****************************************************************
module spi_clock_config_gate_tb_top
  import scg_pkg::*;
;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, xtal = 0, clr = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [3:0]  be = 4'hf;
  scg_mode_e   mode = SCG_RUN;
  logic        wreq, fclk, bclk, act;
  logic [7:0]  frs, brs;
  logic [4:0]  hl, ll;
  logic [2:0]  hv [4] = '{3'h0, 3'h7, 3'h2, 3'h5};
  logic [2:0]  lv [4] = '{3'h0, 3'h7, 3'h5, 3'h2};
  logic [31:0] ev [6] = '{0, 1, 32'h100, 1, 32'h101, 32'h101};
  scg_mode_e   mv [6] = '{SCG_RUN, SCG_RUN, SCG_SLEEP, SCG_SLEEP,
                          SCG_DEEP_SLEEP, SCG_MODE_OFF};
  logic        ov [6] = '{0, 1, 1, 0, 0, 0};
  int          fail_count = 0, n_checks = 0;
  // Clocks; crystal toggles every cycle so baud edges are countable
  always #5 clk = ~clk;
  always @(posedge clk) xtal <= ~xtal;
  scg_top scg_top_i (.clk_sys_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .xtal_clk_i(xtal), .power_mode_i(mode),
    .func_clk_o(fclk), .baud_clk_o(bclk), .func_clk_active_o(act));
  scg_core_model scg_core_model_i (.clk_i(clk), .func_clk_i(fclk),
    .baud_clk_i(bclk), .clr_i(clr), .f_rises_o(frs), .b_rises_o(brs),
    .hi_len_o(hl), .lo_len_o(ll));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // Hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest is read mid-cycle, where it has settled
    do
    begin
      @(negedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0)
      cmp(32'h1, 32'h0);
    q = rdat;
    // The edge that sees waitrequest low ends the access
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rchk
  // Settle past one full period, then count over 40 cycles
  task automatic meas();
    repeat (20) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (40) @(posedge clk);
    @(negedge clk);
  endtask : meas
  task automatic finish_test();
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(8'h2c, 32'h0);
    rchk(8'h30, 32'h0);
    meas();
    cmp(32'(frs), 32'h0);
    bus(1'b1, 8'h2c, 32'hffffffff);
    rchk(8'h2c, 32'h00010707);
    bus(1'b1, 8'h30, 32'hffffffff);
    rchk(8'h30, 32'h00000101);
    bus(1'b1, 8'h34, 32'hffffffff);
    rchk(8'h34, 32'h0);
    be <= 4'h3;
    bus(1'b1, 8'h2c, 32'h0);
    be <= 4'hf;
    rchk(8'h2c, 32'h00010000);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h2c, {15'h0, 1'b1, 5'h0, lv[i], 5'h0, hv[i]});
      meas();
      cmp(32'(hl), 32'(hv[i]) + 32'h1);
      cmp(32'(ll), 32'(lv[i]) + 32'h1);
      cmp(32'(brs), 32'(frs));
    end
    bus(1'b1, 8'h2c, 32'h0);
    meas();
    cmp(32'(brs), 32'h14);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, 8'h30, ev[i]);
      mode <= mv[i];
      meas();
      cmp(32'(frs != 8'h0), 32'(ov[i]));
      cmp(32'(brs != 8'h0), 32'(ov[i]));
    end
    finish_test();
  end
  // Watchdog, well beyond the expected run of about 830 cycles
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : spi_clock_config_gate_tb_top
bind scg_top scg_top_properties scg_top_properties_i (.*);
`default_nettype wire
